//--- pkg/jbcl_pkg.sv
`default_nettype none
package jbcl_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Scan register geometry
  localparam int IR_WIDTH = 6;
  localparam int CFG_WIDTH = 64;
  localparam int CFG_CNT_WIDTH = 6;
  localparam int START_CNT_WIDTH = 4;
  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes, as held in the instruction register
  localparam logic [5:0] OP_CFG_IN = 6'h05;
  localparam logic [5:0] OP_STARTUP_LAUNCH = 6'h0C;
  localparam logic [5:0] OP_BYPASS = 6'h3F;
  localparam logic [5:0] IR_RESET_VALUE = 6'h3F;
  // Capture pattern low bits, fixed by the boundary-scan standard
  localparam logic [1:0] IR_CAPTURE_LSBS = 2'h1;
  ////////////////////////////////////////////////////////////////////////////
  // Timing counts in test clock cycles
  localparam int TLR_TMS_HIGH_CYCLES = 5;
  localparam logic [3:0] STARTUP_TCK_CYCLES = 4'hC;
  localparam logic [5:0] CFG_LAST_BIT = 6'h3F;
  ////////////////////////////////////////////////////////////////////////////
  // Test access port controller states
  typedef enum logic [15:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_SEL_DR     = 16'h0004,
    TAP_CAPTURE_DR = 16'h0008,
    TAP_SHIFT_DR   = 16'h0010,
    TAP_EXIT1_DR   = 16'h0020,
    TAP_PAUSE_DR   = 16'h0040,
    TAP_EXIT2_DR   = 16'h0080,
    TAP_UPDATE_DR  = 16'h0100,
    TAP_SEL_IR     = 16'h0200,
    TAP_CAPTURE_IR = 16'h0400,
    TAP_SHIFT_IR   = 16'h0800,
    TAP_EXIT1_IR   = 16'h1000,
    TAP_PAUSE_IR   = 16'h2000,
    TAP_EXIT2_IR   = 16'h4000,
    TAP_UPDATE_IR  = 16'h8000
  } jbcl_tap_e;
  ////////////////////////////////////////////////////////////////////////////
  // Word handed to the internal configuration bus
  typedef struct packed {
    logic valid;
    logic [63:0] word;
  } jbcl_cfg_bus_s;
endpackage
`default_nettype wire

//--- src/jbcl_loader.sv
`default_nettype none
// Summary of operation
// - Configuration register shifts data from TDI end toward TDO end.
// - Startup runs from TCK in idle; controller gives twelve or more cycles.
// - Five TMS-high cycles reach Test-Logic-Reset; device then fully operational only if startup has already finished.
// - Startup loaded into all devices at once, twelve idle cycles, all active.
// - TDO changes on the falling TCK edge.
// - Instruction register is six bits, loaded over six Shift-IR cycles.
// - Configuration input register is 64 bits, feeding the configuration bus.
module jbcl_loader
  import jbcl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic program_clear_pin_n,
  output jbcl_cfg_bus_s cfg_bus,
  output logic startup_done,
  output logic device_operational
);
  ////////////////////////////////////////////////////////////////////////////
  // Test clock domain reset and pin synchronisers
  logic tck_rst_meta_ff;
  logic tck_rst_ff;
  logic prog_meta_ff;
  logic prog_clear_ff;

  always_ff @(posedge tck)
  begin
    tck_rst_meta_ff <= srst;
    tck_rst_ff <= tck_rst_meta_ff;
    prog_meta_ff <= ~program_clear_pin_n;
    prog_clear_ff <= prog_meta_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // TAP controller
  jbcl_tap_e tap_ff;
  jbcl_tap_e nxt_tap;

  function automatic jbcl_tap_e tap_step(input jbcl_tap_e cur, input logic m);
    case (cur)
      TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_step = m ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_step = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_step = m ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_step = m ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_step = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_step = m ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      default: tap_step = TAP_RESET;
    endcase
  endfunction

  assign nxt_tap = tap_step(tap_ff, tms);

  always_ff @(posedge tck)
  begin
    if (tck_rst_ff)
      tap_ff <= TAP_RESET;
    else
      tap_ff <= nxt_tap;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register
  logic [IR_WIDTH-1:0] ir_shift_ff;
  logic [IR_WIDTH-1:0] ir_ff;
  logic [IR_WIDTH-1:0] nxt_ir_shift;
  logic [IR_WIDTH-1:0] nxt_ir;
  logic startup_ff;
  wire sel_cfg_in = (ir_ff == OP_CFG_IN);
  wire sel_startup = (ir_ff == OP_STARTUP_LAUNCH);

  assign nxt_ir_shift = (tap_ff == TAP_CAPTURE_IR) ?
    {startup_ff, 3'h0, IR_CAPTURE_LSBS} :
    (tap_ff == TAP_SHIFT_IR) ? {tdi, ir_shift_ff[IR_WIDTH-1:1]} : ir_shift_ff;
  assign nxt_ir = (tap_ff == TAP_RESET) ? IR_RESET_VALUE :
    (tap_ff == TAP_UPDATE_IR) ? ir_shift_ff : ir_ff;

  always_ff @(posedge tck)
  begin
    if (tck_rst_ff)
    begin
      ir_shift_ff <= IR_RESET_VALUE;
      ir_ff <= IR_RESET_VALUE;
    end
    else
    begin
      ir_shift_ff <= nxt_ir_shift;
      ir_ff <= nxt_ir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register and bypass bit
  logic [CFG_WIDTH-1:0] cfg_sr_ff;
  logic [CFG_CNT_WIDTH-1:0] cfg_cnt_ff;
  logic [CFG_WIDTH-1:0] cfg_hold_ff;
  logic cfg_tgl_ff;
  logic bypass_ff;
  wire cfg_shift = (tap_ff == TAP_SHIFT_DR) && sel_cfg_in;
  wire cfg_full = cfg_shift && (cfg_cnt_ff == CFG_LAST_BIT);
  wire [CFG_WIDTH-1:0] nxt_cfg_sr = {cfg_sr_ff[CFG_WIDTH-2:0], tdi};

  always_ff @(posedge tck)
  begin
    if (tck_rst_ff)
    begin
      cfg_sr_ff <= '0;
      cfg_cnt_ff <= '0;
      cfg_hold_ff <= '0;
      cfg_tgl_ff <= 1'b0;
      bypass_ff <= 1'b0;
    end
    else
    begin
      if (cfg_shift)
        cfg_sr_ff <= nxt_cfg_sr;
      if (cfg_shift)
        cfg_cnt_ff <= cfg_cnt_ff + 6'h01;
      else if (tap_ff == TAP_CAPTURE_DR)
        cfg_cnt_ff <= '0;
      if (cfg_full)
        cfg_hold_ff <= nxt_cfg_sr;
      if (cfg_full)
        cfg_tgl_ff <= ~cfg_tgl_ff;
      bypass_ff <= (tap_ff == TAP_SHIFT_DR) & tdi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Startup sequence counted on idle test clock cycles
  logic [START_CNT_WIDTH-1:0] start_cnt_ff;
  logic operational_ff;
  wire start_tick = sel_startup && (tap_ff == TAP_IDLE) && !startup_ff;

  always_ff @(posedge tck)
  begin
    if (tck_rst_ff || prog_clear_ff)
    begin
      start_cnt_ff <= '0;
      startup_ff <= 1'b0;
      operational_ff <= 1'b0;
    end
    else
    begin
      if (start_tick)
        start_cnt_ff <= start_cnt_ff + 4'h1;
      if (start_tick && (start_cnt_ff == STARTUP_TCK_CYCLES - 4'h1))
        startup_ff <= 1'b1;
      if (startup_ff && (nxt_tap == TAP_RESET))
        operational_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // TDO driven on the falling edge, only in shift states
  wire in_shift_ir = (tap_ff == TAP_SHIFT_IR);
  wire in_shift_dr = (tap_ff == TAP_SHIFT_DR);
  wire tdo_src = in_shift_ir ? ir_shift_ff[0] :
    sel_cfg_in ? cfg_sr_ff[CFG_WIDTH-1] : bypass_ff;

  always_ff @(negedge tck)
  begin
    if (tck_rst_ff)
    begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo_o <= tdo_src;
      tdo_oe <= in_shift_ir | in_shift_dr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock domain
  logic [2:0] tgl_sync_ff;
  logic done_meta_ff;
  logic done_ff;
  logic oper_meta_ff;
  logic oper_ff;
  wire word_arrived = tgl_sync_ff[2] ^ tgl_sync_ff[1];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tgl_sync_ff <= '0;
      done_meta_ff <= 1'b0;
      done_ff <= 1'b0;
      oper_meta_ff <= 1'b0;
      oper_ff <= 1'b0;
      cfg_bus <= '0;
    end
    else
    begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], cfg_tgl_ff};
      done_meta_ff <= startup_ff;
      done_ff <= done_meta_ff;
      oper_meta_ff <= operational_ff;
      oper_ff <= oper_meta_ff;
      cfg_bus.valid <= word_arrived;
      if (word_arrived)
        cfg_bus.word <= cfg_hold_ff;
    end
  end

  assign startup_done = done_ff;
  assign device_operational = oper_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence tms_high_run_s;
    tms [*5];
  endsequence

  sequence idle_startup_s;
    start_tick;
  endsequence

  tap_reset_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff)
    tms_high_run_s |=> (tap_ff == TAP_RESET))
    else $error("five TMS high cycles did not reach reset");

  ir_load_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff)
    (tap_ff == TAP_UPDATE_IR) |=> (ir_ff == $past(ir_shift_ff)))
    else $error("instruction not loaded on update");

  ir_shift_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff)
    (tap_ff == TAP_SHIFT_IR) |=> (ir_shift_ff[IR_WIDTH-1] == $past(tdi)))
    else $error("instruction shift lost TDI");

  cfg_shift_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff)
    cfg_shift |=> (cfg_sr_ff[0] == $past(tdi)) &&
      (cfg_sr_ff[CFG_WIDTH-1] == $past(cfg_sr_ff[CFG_WIDTH-2])))
    else $error("configuration shift direction wrong");

  cfg_word_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff)
    cfg_full |=> (cfg_hold_ff == cfg_sr_ff) && (cfg_tgl_ff != $past(cfg_tgl_ff)))
    else $error("full word not handed over");

  startup_count_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff || prog_clear_ff)
    $rose(startup_ff) |-> ($past(start_cnt_ff) == STARTUP_TCK_CYCLES - 4'h1))
    else $error("startup finished after wrong cycle count");

  startup_idle_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff || prog_clear_ff)
    !start_tick |=> $stable(start_cnt_ff))
    else $error("startup advanced without startup idle cycle");

  start_advance_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff || prog_clear_ff)
    idle_startup_s |=> (start_cnt_ff == $past(start_cnt_ff) + 4'h1))
    else $error("startup idle cycle not counted");

  operational_a: assert property (
    @(posedge tck) disable iff (tck_rst_ff || prog_clear_ff)
    (startup_ff && nxt_tap == TAP_RESET) |=> operational_ff)
    else $error("not operational after reset with startup done");

  bus_pulse_a: assert property (
    @(posedge clk) disable iff (srst)
    cfg_bus.valid |=> !cfg_bus.valid)
    else $error("configuration word valid longer than one cycle");

  tdo_enable_a: assert property (
    @(negedge tck) disable iff (tck_rst_ff)
    (tap_ff == TAP_IDLE) |=> !tdo_oe)
    else $error("TDO driven outside shift states");

endmodule // jbcl_loader
`default_nettype wire

//--- tb/jbcl_ctrl_model.sv
`default_nettype none
module jbcl_ctrl_model
(
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One test clock cycle; TDO taken at the rising edge, clock parked low
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdo_o;
    #31 tdi = ~d;
    #31.5 tck = 1'b0;
  endtask
  task automatic run(input logic m, input int n);
    logic q;
    repeat (n) tick(m, 1'b0, q);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Instruction load, ends in Exit1-IR
  task automatic ir(input logic [5:0] op);
    logic q;
    run(1'b1, 2);
    run(1'b0, 2);
    for (int i = 0; i < 6; i++) tick(i == 5, op[i], q);
  endtask
  // Data shift, most significant bit first, ends in Update-DR
  task automatic dr(input logic [127:0] d, output logic [127:0] s);
    run(1'b1, 2);
    run(1'b0, 2);
    for (int i = 127; i >= 0; i--) tick(i == 0, d[i], s[i]);
    run(1'b1, 1);
  endtask
endmodule // jbcl_ctrl_model
`default_nettype wire

//--- tb/jbcl_loader_tb.sv
`default_nettype none
module jbcl_loader_tb;
  import jbcl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] W0 = 64'hA5C3_0F1E_9B7D_2468;
  localparam logic [63:0] W1 = 64'h8000_0000_0000_0001;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic program_clear_pin_n = 1'b1;
  wire logic tck, tms, tdi, tdo_o, tdo_oe;
  jbcl_cfg_bus_s cfg_bus;
  logic startup_done, device_operational;
  logic [63:0] words[$];
  int errors = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  jbcl_ctrl_model u_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o));
  jbcl_loader DUT (.clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .program_clear_pin_n(program_clear_pin_n),
    .cfg_bus(cfg_bus), .startup_done(startup_done),
    .device_operational(device_operational));
  always @(posedge clk)
    if (cfg_bus.valid === 1'b1)
      words.push_back(cfg_bus.word);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Two back-to-back words in one pass; TDO echoes the first one
  task automatic t_load;
    logic [127:0] s;
    words.delete();
    u_ctrl.ir(OP_CFG_IN);
    u_ctrl.dr({W0, W1}, s);
    repeat (10) @(posedge clk);
    check("tdo_order", s[63:0], W0);
    check("word_count", 64'(words.size()), 64'h2);
    check("word0", words[0], W0);
    check("word1", words[1], W1);
    check("done_idle", 64'(startup_done), 64'h0);
  endtask
  // Startup needs twelve idle ticks, operational only after reset state
  task automatic t_start;
    u_ctrl.ir(OP_STARTUP_LAUNCH);
    u_ctrl.run(1'b1, 1);
    u_ctrl.run(1'b0, 12);
    repeat (10) @(posedge clk);
    check("done_early", 64'(startup_done), 64'h0);
    u_ctrl.run(1'b0, 1);
    repeat (10) @(posedge clk);
    check("done", 64'(startup_done), 64'h1);
    check("oper_early", 64'(device_operational), 64'h0);
    u_ctrl.run(1'b1, 3);
    repeat (10) @(posedge clk);
    check("oper", 64'(device_operational), 64'h1);
    check("tdo_oe_idle", 64'(tdo_oe), 64'h0);
  endtask
  // Bypass passes TDI to TDO one bit late and hands no word over
  task automatic t_bypass;
    logic [127:0] s;
    words.delete();
    u_ctrl.run(1'b0, 1);
    u_ctrl.ir(OP_BYPASS);
    u_ctrl.dr({W0, W1}, s);
    repeat (10) @(posedge clk);
    check("byp_capture", 64'(s[127]), 64'h0);
    check("byp_delay", s[63:0], {W0[0], W1[63:1]});
    check("byp_words", 64'(words.size()), 64'h0);
  endtask
  // Program clear drops startup state, then a fresh load is accepted
  task automatic t_clear;
    @(posedge clk) program_clear_pin_n <= 1'b0;
    u_ctrl.run(1'b1, 4);
    repeat (10) @(posedge clk);
    check("clr_done", 64'(startup_done), 64'h0);
    check("clr_oper", 64'(device_operational), 64'h0);
    @(posedge clk) program_clear_pin_n <= 1'b1;
    u_ctrl.run(1'b1, 5);
    u_ctrl.run(1'b0, 1);
    t_load();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100us;
    errors++;
    summarize();
  end
  initial
  begin
    fork
      u_ctrl.run(1'b1, 3);
      repeat (8) @(posedge clk);
    join
    srst <= 1'b0;
    u_ctrl.run(1'b1, 5);
    u_ctrl.run(1'b0, 1);
    t_load();
    t_start();
    t_bypass();
    t_clear();
    summarize();
  end
endmodule // jbcl_loader_tb
`default_nettype wire
